// ### rtl/pcl_loader.sv
// configuration word loader with per-port configuration read port
// Operation
// [RL1] even word bit0 sets no-soft-reset bit
// [RL2] word bits 3:1 give aux current
// [RL3] word bit4 reports D1 support
// [RL4] word bit5 reports D2 support
// [RL5] word bits 7:6 give PME support
// [RL6] odd word high byte is pm data
// [RL7] word bit1 selects connector slot clock
// [RL8] word bit2 flags device-specific init
// [RL9] word bit3 counts VC1 as low-priority
// [RL10] word bits 6:4 give logical port number
// [RL11] word bits 15:9 map traffic classes to VC0
// [RL12] only mapped bits change; reads wait for load
`timescale 1ns/10ps
`default_nettype none
module pcl_loader #(
    parameter int NPORTS = pcl_pkg::NUM_PORTS
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire pcl_pkg::pcl_word_type    word_in,
    input  wire logic                     load_done,
    input  wire pcl_pkg::pcl_cfg_req_type cfg_req,
    output var  logic                     cfg_ack,
    output var  logic [31:0]              cfg_rdata,
    output var  logic                     loader_busy
);
    import pcl_pkg::*;

    typedef struct packed {
        pcl_st_type  st;
        logic        ack;
        logic [31:0] rdata;
        logic        busy;
    } pcl_top_type;

    pcl_top_type    state_q;
    pcl_top_type    state_d;
    pcl_word_type   word_gated;
    pcl_fields_type fields [NPORTS];
    pcl_fields_type sel;
    logic           port_ok;
    logic           take;
    logic [31:0]    rd_val;

    // ------------------------------------------------------------
    // per-port field stores
    // ------------------------------------------------------------
    always_comb begin
        word_gated       = word_in;
        word_gated.valid = word_in.valid && (state_q.st == ST_LOAD); // RL12
    end

    for (genvar i = 0; i < NPORTS; i++) begin : g_port
        pcl_port_fields #(
            .PORT_INDEX (i)
        ) u_fields (
            .clk     (clk),
            .rst     (rst),
            .word_in (word_gated),
            .fields  (fields[i])
        );
    end

    // ------------------------------------------------------------
    // register assembly
    // ------------------------------------------------------------
    always_comb begin
        port_ok = 32'(cfg_req.port) < NPORTS;
        sel     = port_ok ? fields[cfg_req.port] : FIELDS_RST;
        rd_val  = 32'h0000_0000;
        case (cfg_req.offset)
            OFS_PMC: begin
                rd_val                = RST_PMC;                // RL12
                rd_val[R_DSI]         = sel.dsi_required;       // RL8
                rd_val[R_AUX+:3]      = sel.aux_current;        // RL2
                rd_val[R_D1]          = sel.d1_support;         // RL3
                rd_val[R_D2]          = sel.d2_support;         // RL4
                rd_val[R_PME+:2]      = sel.pme_support;        // RL5
            end
            OFS_PMCSR: begin
                rd_val                = RST_PMCSR;
                rd_val[R_NSR]         = sel.no_soft_reset;      // RL1
                rd_val[R_PMDATA+:8]   = sel.pm_data;            // RL6
            end
            OFS_LCAP: begin
                rd_val                = RST_LCAP;
                rd_val[R_PORTNUM+:3]  = sel.port_num;           // RL10
            end
            OFS_LCTL: begin
                rd_val                = RST_LCTL;
                rd_val[R_SLOTCLK]     = sel.slot_clock;         // RL7
            end
            OFS_VCCAP: begin
                rd_val                = RST_VCCAP;
                rd_val[R_LOWPRIO]     = sel.low_priority_vc_count; // RL9
            end
            OFS_VC0CTL: begin
                rd_val                = RST_VC0CTL;
                rd_val[R_TCMAP+:7]    = sel.tc_map;             // RL11
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
        if (!port_ok) begin
            rd_val = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // load phase and read handshake
    // ------------------------------------------------------------
    assign take = cfg_req.valid && (state_q.st == ST_READY) && !state_q.ack; // RL12

    always_comb begin
        state_d     = state_q;
        state_d.ack = 1'b0;
        case (state_q.st)
            ST_LOAD: begin
                if (load_done) begin
                    state_d.st   = ST_READY;
                    state_d.busy = 1'b0;
                end
            end
            ST_READY: begin
                if (take) begin
                    state_d.ack   = 1'b1;
                    state_d.rdata = rd_val;
                end
            end
            default: begin
                state_d.st = ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '{st: ST_LOAD, ack: 1'b0, rdata: 32'h0000_0000, busy: 1'b1};
        end else begin
            state_q <= state_d;
        end
    end

    assign cfg_ack     = state_q.ack;
    assign cfg_rdata   = state_q.rdata;
    assign loader_busy = state_q.busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_no_ack_loading;
        loader_busy |=> !cfg_ack;
    endproperty
    a_no_ack_loading: assert property (p_no_ack_loading) else $error("read served during load"); // RL12

    property p_ack_follows;
        take |=> cfg_ack ##1 !cfg_ack;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("ack not a single pulse"); // RL12

    property p_pmc_d1d2;
        take && cfg_req.offset == OFS_PMC && port_ok
            |=> cfg_rdata[R_D1] == $past(sel.d1_support) && cfg_rdata[R_D2] == $past(sel.d2_support)
                && cfg_rdata[R_AUX+:3] == $past(sel.aux_current);
    endproperty
    a_pmc_d1d2: assert property (p_pmc_d1d2) else $error("pm capability read wrong"); // RL3

    property p_pmc_other;
        take && cfg_req.offset == OFS_PMC && port_ok
            |=> cfg_rdata[20:0] == RST_PMC[20:0] && cfg_rdata[31:30] == RST_PMC[31:30];
    endproperty
    a_pmc_other: assert property (p_pmc_other) else $error("unmapped pm bits changed"); // RL12

    property p_vc0_map;
        take && cfg_req.offset == OFS_VC0CTL && port_ok
            |=> cfg_rdata[7:1] == $past(sel.tc_map) && cfg_rdata[0] == RST_VC0CTL[0];
    endproperty
    a_vc0_map: assert property (p_vc0_map) else $error("tc map read wrong"); // RL11

    property p_busy_ends;
        loader_busy && load_done |=> !loader_busy;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("load phase did not end"); // RL12

    property p_pmcsr_read;
        take && cfg_req.offset == OFS_PMCSR && port_ok
            |=> cfg_rdata[R_NSR] == $past(sel.no_soft_reset)
                && cfg_rdata[R_PMDATA+:8] == $past(sel.pm_data);
    endproperty
    a_pmcsr_read: assert property (p_pmcsr_read) else $error("pm control read wrong"); // RL6

    property p_pmc_dsi_pme;
        take && cfg_req.offset == OFS_PMC && port_ok
            |=> cfg_rdata[R_DSI] == $past(sel.dsi_required)
                && cfg_rdata[R_PME+:2] == $past(sel.pme_support);
    endproperty
    a_pmc_dsi_pme: assert property (p_pmc_dsi_pme) else $error("pm capability flags read wrong"); // RL8

    property p_lcap_portnum;
        take && cfg_req.offset == OFS_LCAP && port_ok
            |=> cfg_rdata[R_PORTNUM+:3] == $past(sel.port_num);
    endproperty
    a_lcap_portnum: assert property (p_lcap_portnum) else $error("port number read wrong"); // RL10

    property p_lctl_slot;
        take && cfg_req.offset == OFS_LCTL && port_ok
            |=> cfg_rdata[R_SLOTCLK] == $past(sel.slot_clock);
    endproperty
    a_lctl_slot: assert property (p_lctl_slot) else $error("slot clock read wrong"); // RL7

    property p_vccap_lowprio;
        take && cfg_req.offset == OFS_VCCAP && port_ok
            |=> cfg_rdata[R_LOWPRIO] == $past(sel.low_priority_vc_count);
    endproperty
    a_vccap_lowprio: assert property (p_vccap_lowprio) else $error("low priority vc read wrong"); // RL9

    property p_bad_port_zero;
        take && !port_ok
            |=> cfg_rdata == 32'h0000_0000;
    endproperty
    a_bad_port_zero: assert property (p_bad_port_zero) else $error("absent port read not zero"); // RL12

    c_load_end: cover property (loader_busy ##1 !loader_busy);
    c_pmc_read: cover property (take && cfg_req.offset == OFS_PMC ##1 cfg_ack);
    c_vc0_read: cover property (take && cfg_req.offset == OFS_VC0CTL ##1 cfg_ack);
    c_bad_port: cover property (take && !port_ok ##1 cfg_ack);
endmodule
`default_nettype wire

// ### rtl/pcl_pkg.sv
// package for the per-port configuration word loader
`default_nettype none
package pcl_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int          NUM_PORTS      = 6;
    localparam int          PORT_W         = 3;
    localparam int          WADDR_W        = 8;
    localparam int          WDATA_W        = 16;
    localparam int          OFS_W          = 12;
    localparam int          PORT_STRIDE    = 2;
    localparam logic [7:0]  PM_WORD_BASE   = 8'h50;
    localparam logic [7:0]  MISC_WORD_BASE = 8'h60;

    // ------------------------------------------------------------
    // configuration offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_PMC    = 12'h040;
    localparam logic [11:0] OFS_PMCSR  = 12'h044;
    localparam logic [11:0] OFS_LCAP   = 12'h0CC;
    localparam logic [11:0] OFS_LCTL   = 12'h0D0;
    localparam logic [11:0] OFS_VCCAP  = 12'h144;
    localparam logic [11:0] OFS_VC0CTL = 12'h154;

    // ------------------------------------------------------------
    // hardware defaults of the target registers
    // ------------------------------------------------------------
    localparam logic [31:0] RST_PMC    = 32'h0603_0001;
    localparam logic [31:0] RST_PMCSR  = 32'h0000_0000;
    localparam logic [31:0] RST_LCAP   = 32'h0000_0000;
    localparam logic [31:0] RST_LCTL   = 32'h0000_0000;
    localparam logic [31:0] RST_VCCAP  = 32'h0000_0001;
    localparam logic [31:0] RST_VC0CTL = 32'h8000_0001;

    // ------------------------------------------------------------
    // loader word bit positions
    // ------------------------------------------------------------
    localparam int W_NSR     = 0;
    localparam int W_AUX     = 1;
    localparam int W_D1      = 4;
    localparam int W_D2      = 5;
    localparam int W_PME     = 6;
    localparam int W_PMDATA  = 8;
    localparam int W_SLOTCLK = 1;
    localparam int W_DSI     = 2;
    localparam int W_LOWPRIO = 3;
    localparam int W_PORTNUM = 4;
    localparam int W_TCMAP   = 9;

    // ------------------------------------------------------------
    // target register bit positions
    // ------------------------------------------------------------
    localparam int R_NSR     = 3;
    localparam int R_PMDATA  = 24;
    localparam int R_DSI     = 21;
    localparam int R_AUX     = 22;
    localparam int R_D1      = 25;
    localparam int R_D2      = 26;
    localparam int R_PME     = 28;
    localparam int R_SLOTCLK = 28;
    localparam int R_LOWPRIO = 4;
    localparam int R_PORTNUM = 24;
    localparam int R_TCMAP   = 1;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 valid;
        logic [WADDR_W-1:0]   addr;
        logic [WDATA_W-1:0]   data;
    } pcl_word_type;

    typedef struct packed {
        logic                 valid;
        logic [PORT_W-1:0]    port;
        logic [OFS_W-1:0]     offset;
    } pcl_cfg_req_type;

    typedef struct packed {
        logic       no_soft_reset;
        logic [2:0] aux_current;
        logic       d1_support;
        logic       d2_support;
        logic [1:0] pme_support;
        logic [7:0] pm_data;
        logic       slot_clock;
        logic       dsi_required;
        logic       low_priority_vc_count;
        logic [2:0] port_num;
        logic [6:0] tc_map;
    } pcl_fields_type;

    localparam pcl_fields_type FIELDS_RST = '{
        no_soft_reset: RST_PMCSR[R_NSR],
        aux_current:   RST_PMC[R_AUX+:3],
        d1_support:    RST_PMC[R_D1],
        d2_support:    RST_PMC[R_D2],
        pme_support:   RST_PMC[R_PME+:2],
        pm_data:       RST_PMCSR[R_PMDATA+:8],
        slot_clock:    RST_LCTL[R_SLOTCLK],
        dsi_required:  RST_PMC[R_DSI],
        low_priority_vc_count: RST_VCCAP[R_LOWPRIO],
        port_num:      RST_LCAP[R_PORTNUM+:3],
        tc_map:        RST_VC0CTL[R_TCMAP+:7]
    };

    typedef enum logic {ST_LOAD, ST_READY} pcl_st_type;
endpackage
`default_nettype wire

// ### rtl/pcl_port_fields.sv
// loaded configuration fields of one port
`timescale 1ns/10ps
`default_nettype none
module pcl_port_fields #(
    parameter int PORT_INDEX = 0
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire pcl_pkg::pcl_word_type   word_in,
    output var  pcl_pkg::pcl_fields_type fields
);
    import pcl_pkg::*;

    localparam logic [7:0] A_EVEN = 8'(PM_WORD_BASE + PORT_STRIDE * PORT_INDEX);
    localparam logic [7:0] A_ODD  = 8'(PM_WORD_BASE + PORT_STRIDE * PORT_INDEX + 1);
    localparam logic [7:0] A_MISC = 8'(MISC_WORD_BASE + PORT_STRIDE * PORT_INDEX);

    pcl_fields_type state_q;
    pcl_fields_type state_d;
    logic           hit_even;
    logic           hit_odd;
    logic           hit_misc;

    assign hit_even = word_in.valid && (word_in.addr == A_EVEN);
    assign hit_odd  = word_in.valid && (word_in.addr == A_ODD);
    assign hit_misc = word_in.valid && (word_in.addr == A_MISC);
    assign fields   = state_q;

    // ------------------------------------------------------------
    // word to field mapping
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (hit_even) begin
            state_d.no_soft_reset = word_in.data[W_NSR];      // RL1
            state_d.aux_current   = word_in.data[W_AUX+:3];   // RL2
            state_d.d1_support    = word_in.data[W_D1];       // RL3
            state_d.d2_support    = word_in.data[W_D2];       // RL4
            state_d.pme_support   = word_in.data[W_PME+:2];   // RL5
        end
        if (hit_odd) begin
            state_d.pm_data = word_in.data[W_PMDATA+:8];      // RL6
        end
        if (hit_misc) begin
            state_d.slot_clock            = word_in.data[W_SLOTCLK];    // RL7
            state_d.dsi_required          = word_in.data[W_DSI];        // RL8
            state_d.low_priority_vc_count = word_in.data[W_LOWPRIO];    // RL9
            state_d.port_num              = word_in.data[W_PORTNUM+:3]; // RL10
            state_d.tc_map                = word_in.data[W_TCMAP+:7];   // RL11
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= FIELDS_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_nsr;
        hit_even |=> fields.no_soft_reset == $past(word_in.data[W_NSR]);
    endproperty
    a_nsr: assert property (p_nsr) else $error("soft reset bit not loaded"); // RL1

    property p_pmc_caps;
        hit_even |=> fields.aux_current == $past(word_in.data[3:1])
            && fields.d1_support == $past(word_in.data[4])
            && fields.d2_support == $past(word_in.data[5])
            && fields.pme_support == $past(word_in.data[7:6]);
    endproperty
    a_pmc_caps: assert property (p_pmc_caps) else $error("pm capability not loaded"); // RL2

    property p_pmdata;
        hit_odd |=> fields.pm_data == $past(word_in.data[15:8]);
    endproperty
    a_pmdata: assert property (p_pmdata) else $error("pm data not loaded"); // RL6

    property p_misc;
        hit_misc |=> fields.slot_clock == $past(word_in.data[1])
            && fields.dsi_required == $past(word_in.data[2])
            && fields.low_priority_vc_count == $past(word_in.data[3]);
    endproperty
    a_misc: assert property (p_misc) else $error("misc bits not loaded"); // RL7

    property p_portnum_map;
        hit_misc |=> fields.port_num == $past(word_in.data[6:4])
            && fields.tc_map == $past(word_in.data[15:9]);
    endproperty
    a_portnum_map: assert property (p_portnum_map) else $error("port number or map not loaded"); // RL10

    property p_hold;
        !word_in.valid |=> $stable(fields);
    endproperty
    a_hold: assert property (p_hold) else $error("fields changed without a word"); // RL12
endmodule
`default_nettype wire

// ### tb/pcl_cfg_mem_model.sv
// behavioural serial configuration memory that streams loader words
`timescale 1ns/10ps
`default_nettype none
module pcl_cfg_mem_model (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  start,
    output var  pcl_pkg::pcl_word_type word_out,
    output var  logic                  busy
);
    import pcl_pkg::*;
    logic [15:0] mem [0:255];
    logic [4:0]  idx;

    // ----------
    // word stream: pm words 50h..5Bh, then misc words 60h+2p
    // ----------
    function automatic logic [7:0] seq_addr(input logic [4:0] i);
        if (i < 5'd12) begin
            return PM_WORD_BASE + {3'h0, i};
        end
        return MISC_WORD_BASE + {2'h0, i - 5'd12, 1'b0};
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy     <= 1'b0;
            idx      <= 5'h00;
            word_out <= '0;
        end else if (busy) begin
            word_out <= '{valid: 1'b1, addr: seq_addr(idx), data: mem[seq_addr(idx)]};
            idx      <= idx + 5'h01;
            busy     <= (idx != 5'd17);
        end else begin
            // released data lines do not keep the last value
            word_out.valid <= 1'b0;
            word_out.data  <= ~word_out.data;
            busy           <= start;
            idx            <= 5'h00;
        end
    end
endmodule
`default_nettype wire

// ### tb/test_pcl_loader.sv
// self-checking bench of the configuration word loader
`timescale 1ns/10ps
`default_nettype none
module test_pcl_loader;
    import pcl_pkg::*;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            start = 1'b0;
    logic            load_done = 1'b0;
    logic            dflt = 1'b0;
    pcl_word_type    tb_word = '0;
    pcl_word_type    mdl_word;
    pcl_word_type    word_in;
    pcl_cfg_req_type cfg_req = '0;
    logic            cfg_ack;
    logic [31:0]     cfg_rdata;
    logic            loader_busy;
    logic            mdl_busy;
    logic [15:0]     img [0:255];
    logic [31:0]     seed = 32'h0000_27BC;
    logic [11:0]     ofs_tab [0:6] = '{OFS_PMC, OFS_PMCSR, OFS_LCAP, OFS_LCTL, OFS_VCCAP, OFS_VC0CTL, 12'h048};
    int              bad_count = 0;
    int              n_checks = 0;
    int              cyc = 0;

    always #25 clk = ~clk;
    assign word_in = mdl_word.valid ? mdl_word : tb_word;

    pcl_loader #(.NPORTS(NUM_PORTS)) dut (
        .clk(clk), .rst(rst), .word_in(word_in), .load_done(load_done), .cfg_req(cfg_req),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .loader_busy(loader_busy));
    pcl_cfg_mem_model mdl (.clk(clk), .rst(rst), .start(start), .word_out(mdl_word), .busy(mdl_busy));

    // ----------
    // helpers
    // ----------
    task automatic finish_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] nxt(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [31:0] exp_reg(input int p, input logic [11:0] ofs);
        logic [15:0] e;
        logic [15:0] o;
        logic [15:0] m;
        logic [31:0] r;
        e = img[8'h50 + 2 * p];
        o = img[8'h51 + 2 * p];
        m = img[8'h60 + 2 * p];
        r = 32'h0000_0000;
        if (p < NUM_PORTS) begin
            case (ofs)
                OFS_PMC: begin
                    r = RST_PMC;
                    if (!dflt) begin
                        r[26:22] = e[5:1];
                        r[29:28] = e[7:6];
                        r[21]    = m[2];
                    end
                end
                OFS_PMCSR: begin
                    r = RST_PMCSR;
                    if (!dflt) begin
                        r[3]     = e[0];
                        r[31:24] = o[15:8];
                    end
                end
                OFS_LCAP: r = dflt ? RST_LCAP : {RST_LCAP[31:27], m[6:4], RST_LCAP[23:0]};
                OFS_LCTL: r = dflt ? RST_LCTL : {RST_LCTL[31:29], m[1], RST_LCTL[27:0]};
                OFS_VCCAP: r = dflt ? RST_VCCAP : {RST_VCCAP[31:5], m[3], RST_VCCAP[3:0]};
                OFS_VC0CTL: r = dflt ? RST_VC0CTL : {RST_VC0CTL[31:8], m[15:9], RST_VC0CTL[0]};
                default: r = 32'h0000_0000;
            endcase
        end
        return r;
    endfunction

    task automatic put(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        tb_word <= '{valid: 1'b1, addr: a, data: d};
        @(posedge clk);
        tb_word <= '{valid: 1'b0, addr: a, data: ~d};
    endtask

    task automatic wait_ack(input logic [31:0] exp, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cfg_ack !== 1'b1 && n < 20);
        cfg_req.valid <= 1'b0;
        check(cfg_rdata, exp);
    endtask

    task automatic rd(input int p, input logic [11:0] o);
        int n;
        @(posedge clk);
        cfg_req <= '{valid: 1'b1, port: 3'(p), offset: o};
        wait_ack(exp_reg(p, o), n);
        check(32'(n), 32'd2);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            finish_test();
        end
    end

    // ----------
    // main sequence
    // ----------
    initial begin
        int n;
        for (int i = 0; i < 256; i++) begin
            seed = nxt(seed);
            img[i] = seed[15:0];
        end
        img[8'h60] = 16'hFFFF;
        img[8'h6A] = 16'h0000;
        for (int i = 0; i < 256; i++) begin
            mdl.mem[i] = img[i];
        end
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        while (mdl_busy) @(posedge clk);
        put(8'h56, ~img[8'h56]);
        img[8'h56] = ~img[8'h56];
        put(8'h5C, 16'hFFFF);
        put(8'h61, 16'hFFFF);
        @(posedge clk);
        cfg_req <= '{valid: 1'b1, port: 3'd3, offset: OFS_PMCSR};
        repeat (4) begin
            @(posedge clk);
            check({31'h0, cfg_ack}, 32'h0);
            check({31'h0, loader_busy}, 32'h1);
        end
        load_done <= 1'b1;
        @(posedge clk);
        load_done <= 1'b0;
        wait_ack(exp_reg(3, OFS_PMCSR), n);
        check({31'h0, loader_busy}, 32'h0);
        put(8'h56, 16'h0000);
        for (int q = 0; q < 8; q++) begin
            for (int k = 0; k < 7; k++) begin
                rd(q, ofs_tab[k]);
            end
        end
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        dflt = 1'b1;
        @(posedge clk);
        check({31'h0, loader_busy}, 32'h1);
        check({31'h0, cfg_ack}, 32'h0);
        check(cfg_rdata, 32'h0000_0000);
        load_done <= 1'b1;
        @(posedge clk);
        load_done <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            rd(5, ofs_tab[k]);
        end
        finish_test();
    end
endmodule
`default_nettype wire
